// ---- tcss_device.sv ----
// Purpose: transmitter side config shift-in, start-up sequencer and modulation routing
// Assumes: host keeps sck at or below 2 MHz and sends exactly 32 bits per enable
// Notes: all pins are synchronised to clk_sys, so edges are seen about 2 cycles late
// Operation
// - sample data on each rising serial clock
// - host sends exactly 32 bits after enable
// - latch word on falling edge after last bit
// - after 32 bits, pin becomes transmit data
// - pin modulates either amplitude or frequency keying, never both
// - route data to amplitude or frequency path
// - config bit selects amplitude or frequency keying
// - amplitude keying switches amplifier with data
// - host serial clock at most 2 MHz
// - host holds data and clock low when off
// - oscillator starts at once on enable
// - clock out once oscillator stable, programming done
// - slow programming: clock out at completion
// - amplifier on 98.46 us after clock start
// - ignore serial clock during transmission
// - host drops enable, clock, data after sending
// - clock only mode keeps oscillator, clock driver
// - divider select bit sets clock output ratio
// - clock output only when enable bit set
// - four bit field sets amplifier output power
`timescale 1ns/10ps
module tcss_device #(
  parameter int unsigned OSC_START_CYC = tcss_pkg::OSC_START_CYC_DEF // oscillator settle
) (
  input wire logic clk_sys,               // system clock, 40 MHz
  input wire logic rst_n,                 // async reset, active low
  tcss_link_if.device link,               // pins to host
  output logic crystal_oscillator_on,     // oscillator running
  output logic config_done,               // 32-bit word latched
  output logic tx_active,                 // transmit phase reached
  output logic pa_on,                     // power amplifier switched on
  output logic amplitude_mod_signal,      // data into amplitude path
  output logic frequency_mod_signal,      // data into frequency path
  output logic [tcss_pkg::PWR_W-1:0] output_power_level // amplifier level
);
  import tcss_pkg::*;

  logic [2:0] pins_s;
  logic en_s;
  logic sck_s;
  logic sdin_s;
  logic sck_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic [CFG_BITS-1:0] shift_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [CFG_BITS-1:0] cfg_q;
  logic prog_done_q;
  logic [OSC_CNT_W-1:0] osc_cnt_q;
  logic osc_ready_q;
  logic [PLL_CNT_W-1:0] pll_cnt_q;
  tcss_dev_state_t state_q;
  logic clk_run;
  logic [1:0] div_cnt_q;
  logic clk_out_q;
  logic mod_ask;
  logic clk_only;
  logic tx_now;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  tcss_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({link.en, link.sck, link.serial_in_tx_data}),
    .q(pins_s)
  );
  assign en_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdin_s = pins_s[0];

  // edge detection looks only at synchronised levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // ----------------------------------------------------------------
  // configuration shift-in
  // ----------------------------------------------------------------
  // extra edges past 32 are dropped, the word is never overwritten mid frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= CFG_RESET;
      bit_cnt_q <= '0;
    end else if (!en_s) begin
      shift_q <= CFG_RESET;
      bit_cnt_q <= '0;
    end else if (!prog_done_q && sck_rise && bit_cnt_q != BIT_CNT_W'(CFG_BITS)) begin
      shift_q <= {shift_q[CFG_BITS-2:0], sdin_s};
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // latch on the falling clock after the least significant bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
      prog_done_q <= 1'b0;
    end else if (!en_s) begin
      cfg_q <= CFG_RESET;
      prog_done_q <= 1'b0;
    end else if (!prog_done_q && sck_fall && bit_cnt_q == BIT_CNT_W'(CFG_BITS)) begin
      cfg_q <= shift_q;
      prog_done_q <= 1'b1;
    end
  end

  assign mod_ask = cfg_q[MOD_TYPE_BIT];
  assign clk_only = cfg_q[CLK_ONLY_BIT];

  // ----------------------------------------------------------------
  // crystal oscillator start-up model
  // ----------------------------------------------------------------
  // counts from enable in parallel with programming
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= '0;
      osc_ready_q <= 1'b0;
      crystal_oscillator_on <= 1'b0;
    end else if (!en_s) begin
      osc_cnt_q <= '0;
      osc_ready_q <= 1'b0;
      crystal_oscillator_on <= 1'b0;
    end else begin
      crystal_oscillator_on <= 1'b1;
      if (!osc_ready_q) begin
        if (osc_cnt_q == OSC_CNT_W'(OSC_START_CYC - 1)) begin
          osc_ready_q <= 1'b1;
        end
        osc_cnt_q <= osc_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  // clock starts at the later of oscillator ready and word latched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TCSS_OFF;
      pll_cnt_q <= '0;
    end else if (!en_s) begin
      state_q <= TCSS_OFF;
      pll_cnt_q <= '0;
    end else begin
      case (state_q)
        TCSS_OFF: begin
          state_q <= TCSS_START;
        end
        TCSS_START: begin
          if (osc_ready_q && prog_done_q) begin
            state_q <= TCSS_PLL;
            pll_cnt_q <= '0;
          end
        end
        TCSS_PLL: begin
          if (pll_cnt_q == PLL_CNT_W'(PLL_CYC - 1)) begin
            state_q <= TCSS_TX;
          end else begin
            pll_cnt_q <= pll_cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= TCSS_TX;
        end
      endcase
    end
  end
  assign clk_run = (state_q == TCSS_PLL) || (state_q == TCSS_TX);

  // ----------------------------------------------------------------
  // clock output divider
  // ----------------------------------------------------------------
  function automatic logic [1:0] half_count(input logic sel);
    half_count = sel ? DIV_HALF_HI : DIV_HALF_LO;
  endfunction

  // output held low whenever the enable bit is clear, clock only mode included
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 2'h0;
      clk_out_q <= 1'b0;
    end else if (!(clk_run && cfg_q[CLK_OE_BIT])) begin
      div_cnt_q <= 2'h0;
      clk_out_q <= 1'b0;
    end else if (div_cnt_q == half_count(cfg_q[DIV_SEL_BIT]) - 2'h1) begin
      div_cnt_q <= 2'h0;
      clk_out_q <= ~clk_out_q;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
    end
  end
  assign link.clk_out = clk_out_q;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  // clock only mode never reaches the amplifier or the modulators
  assign tx_now = (state_q == TCSS_TX) && !clk_only;
  // one register stage only, kept so every output is a flip-flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_active <= 1'b0;
      pa_on <= 1'b0;
      amplitude_mod_signal <= 1'b0;
      frequency_mod_signal <= 1'b0;
      output_power_level <= '0;
      config_done <= 1'b0;
    end else begin
      config_done <= prog_done_q;
      tx_active <= tx_now;
      amplitude_mod_signal <= tx_now && mod_ask && sdin_s;
      frequency_mod_signal <= tx_now && !mod_ask && sdin_s;
      pa_on <= tx_now && (mod_ask ? sdin_s : 1'b1);
      output_power_level <= tx_now ? cfg_q[PWR_LSB +: PWR_W] : '0;
    end
  end
endmodule

// ---- tcss_pkg.sv ----
// Purpose: shared constants for the transmitter config and start sequencer
// Assumes: clk_sys at 40 MHz, config word shifted most significant bit first
// Notes: field positions inside the 32-bit word are fixed here and used by the device end only
package tcss_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_HZ = 40_000_000;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned OSC_START_NS = 200_000;   // osc_startup_time, typical
  localparam int unsigned OSC_START_CYC_DEF = OSC_START_NS / CLK_NS;
  localparam int unsigned PLL_DELAY_NS = 98_460;    // 98.46 us, least time
  localparam int unsigned PLL_CYC = (PLL_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SCK_MAX_HZ = 2_000_000;
  localparam int unsigned SCK_HALF_CYC = (SYS_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  localparam int unsigned OSC_CNT_W = 16;
  localparam int unsigned PLL_CNT_W = 12;
  localparam int unsigned PH_CNT_W = 5;
  // ----------------------------------------------------------------
  // configuration word layout
  // ----------------------------------------------------------------
  localparam int unsigned CFG_BITS = 32;
  localparam int unsigned BIT_CNT_W = 6;
  localparam int unsigned PWR_W = 4;
  localparam int unsigned MOD_TYPE_BIT = 31;        // 1 = amplitude, 0 = frequency keying
  localparam int unsigned PWR_LSB = 27;             // output_power_level in [30:27]
  localparam int unsigned DIV_SEL_BIT = 26;         // clock_divider_select
  localparam int unsigned CLK_OE_BIT = 25;          // clock output enable
  localparam int unsigned CLK_ONLY_BIT = 24;        // clock only mode
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [3:0] PWR_MAX = 4'hf;            // highest output power, 12.5 dBm
  // clock output half periods in clk_sys cycles
  localparam logic [1:0] DIV_HALF_LO = 2'h1;        // select 0: clk_sys / 2
  localparam logic [1:0] DIV_HALF_HI = 2'h2;        // select 1: clk_sys / 4
  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCSS_OFF = 2'b00,
    TCSS_START = 2'b01,
    TCSS_PLL = 2'b10,
    TCSS_TX = 2'b11
  } tcss_dev_state_t;
  typedef enum logic [1:0] {
    TCSS_H_IDLE = 2'b00,
    TCSS_H_SETUP = 2'b01,
    TCSS_H_SHIFT = 2'b10,
    TCSS_H_SEND = 2'b11
  } tcss_host_state_t;
endpackage

// ---- tcss_link_if.sv ----
// Purpose: pin level link between host processor and transmitter
// Assumes: all pins are plain one-way wires, no tri-state
// Notes: the serial data pin doubles as transmit data after configuration
`timescale 1ns/10ps
interface tcss_link_if;
  logic en;            // enable, high powers the transmitter
  logic sck;           // serial clock from host
  logic serial_in_tx_data; // config data, then transmit data
  logic clk_out;       // divided oscillator clock to host
  modport device (
    input en,
    input sck,
    input serial_in_tx_data,
    output clk_out
  );
  modport host (
    output en,
    output sck,
    output serial_in_tx_data,
    input clk_out
  );
endinterface

// ---- tcss_sync.sv ----
// Purpose: two flip-flop synchroniser for the three link inputs
// Assumes: inputs are asynchronous to clk_sys
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module tcss_sync (
  input wire logic clk_sys, // system clock
  input wire logic rst_n,   // async reset, active low
  input wire logic [2:0] d, // raw pin levels
  output logic [2:0] q      // synchronised levels
);
  logic [2:0] meta_q;
  // ----------------------------------------------------------------
  // two stage capture
  // ----------------------------------------------------------------
  // pins are held low while off, so zero is the safe reset value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 3'h0;
      q <= 3'h0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- tcss_host.sv ----
// Purpose: host side driver that powers, programs and feeds the transmitter
// Assumes: user keeps tx_bit stable for its own bit period
// Notes: serial clock runs at exactly the 2 MHz ceiling
`timescale 1ns/10ps
module tcss_host (
  input wire logic clk_sys,            // system clock, 40 MHz
  input wire logic rst_n,              // async reset, active low
  tcss_link_if.host link,              // pins to transmitter
  input wire logic start,              // pulse: power up and program
  input wire logic stop,               // pulse: power down
  input wire logic [31:0] cfg_word,    // word taken on start
  input wire logic tx_bit,             // data driven during send phase
  output logic busy,                   // enable is high
  output logic sending                 // programming done, tx_bit on pin
);
  import tcss_pkg::*;

  tcss_host_state_t state_q;
  logic [CFG_BITS-1:0] shreg_q;
  logic [BIT_CNT_W-1:0] bits_q;
  logic [PH_CNT_W-1:0] ph_q;
  logic en_q;
  logic sck_q;
  logic sd_q;
  logic ph_end;

  assign ph_end = (ph_q == PH_CNT_W'(SCK_HALF_CYC - 1));

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  // half period count keeps sck at or below the device limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TCSS_H_IDLE;
      shreg_q <= '0;
      bits_q <= '0;
      ph_q <= '0;
      en_q <= 1'b0;
      sck_q <= 1'b0;
      sd_q <= 1'b0;
    end else if (stop) begin
      state_q <= TCSS_H_IDLE;
      en_q <= 1'b0;
      sck_q <= 1'b0;
      sd_q <= 1'b0;
    end else begin
      ph_q <= ph_end ? '0 : ph_q + 1'b1;
      case (state_q)
        TCSS_H_IDLE: begin
          en_q <= 1'b0;
          sck_q <= 1'b0;
          sd_q <= 1'b0;
          ph_q <= '0;
          if (start) begin
            en_q <= 1'b1;
            shreg_q <= cfg_word;
            bits_q <= '0;
            state_q <= TCSS_H_SETUP;
          end
        end
        TCSS_H_SETUP: begin
          sd_q <= shreg_q[CFG_BITS-1];
          if (ph_end) begin
            state_q <= TCSS_H_SHIFT;
          end
        end
        TCSS_H_SHIFT: begin
          if (ph_end) begin
            if (!sck_q) begin
              sck_q <= 1'b1;
            end else begin
              sck_q <= 1'b0;
              shreg_q <= {shreg_q[CFG_BITS-2:0], 1'b0};
              sd_q <= shreg_q[CFG_BITS-2];
              bits_q <= bits_q + 1'b1;
              if (bits_q == BIT_CNT_W'(CFG_BITS - 1)) begin
                state_q <= TCSS_H_SEND;
              end
            end
          end
        end
        default: begin
          sck_q <= 1'b0;
          sd_q <= tx_bit;
        end
      endcase
    end
  end

  assign link.en = en_q;
  assign link.sck = sck_q;
  assign link.serial_in_tx_data = sd_q;

  // ----------------------------------------------------------------
  // user status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      sending <= 1'b0;
    end else begin
      busy <= en_q;
      sending <= (state_q == TCSS_H_SEND) && !stop;
    end
  end
endmodule

// ---- tcss_monitor.sv ----
// Purpose: concurrent checks on the host to transmitter link and device outputs
// Assumes: one clk_sys domain, rst_n async active low
// Notes: timing windows allow for the two-flop pin synchroniser
`timescale 1ns/10ps
module tcss_monitor (
  input wire logic clk_sys,                              // system clock
  input wire logic rst_n,                                // async reset, active low
  input wire logic en,                                   // enable pin
  input wire logic sck,                                  // serial clock pin
  input wire logic serial_in_tx_data,                    // config then tx data pin
  input wire logic clk_out,                              // divided clock pin
  input wire logic crystal_oscillator_on,                // oscillator running
  input wire logic config_done,                          // word latched
  input wire logic tx_active,                            // transmit phase
  input wire logic pa_on,                                // amplifier on
  input wire logic amplitude_mod_signal,                 // amplitude path data
  input wire logic frequency_mod_signal,                 // frequency path data
  input wire logic [tcss_pkg::PWR_W-1:0] output_power_level // amplifier level
);
  import tcss_pkg::*;
  // ----------------------------------------------------------------
  // helper: cycles since the clock output first rose in this power-up
  // ----------------------------------------------------------------
  logic seen_q;
  logic [12:0] cnt_q;
  // cleared on the pin, not the device state, so a late clk_out cannot leak over
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) seen_q <= 1'b0;
    else if (!en) seen_q <= 1'b0;
    else if (clk_out) seen_q <= 1'b1;
  end
  // saturating, so a long clock-only run never wraps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt_q <= 13'h0000;
    else if (!seen_q) cnt_q <= 13'h0000;
    else if (cnt_q != 13'h1fff) cnt_q <= cnt_q + 13'h0001;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_osc_on_enable: assert property ($rose(en) |-> ##[2:5] crystal_oscillator_on)
    else $error("oscillator did not start after enable");
  a_off_clears_all: assert property ($fell(en) |->
    ##8 !(crystal_oscillator_on || config_done || tx_active || pa_on || clk_out))
    else $error("outputs still active after enable low");
  a_clk_needs_cfg: assert property ($rose(clk_out) |-> config_done && crystal_oscillator_on)
    else $error("clock output before word latched or oscillator on");
  a_clk_half_len: assert property ($rose(clk_out) |-> ##[1:2] !clk_out)
    else $error("clock output high phase too long");
  a_mod_path_excl: assert property (!(amplitude_mod_signal && frequency_mod_signal))
    else $error("data on both modulation paths");
  a_ask_keys_pa: assert property (amplitude_mod_signal |-> pa_on)
    else $error("amplitude data high with amplifier off");
  a_pa_in_tx: assert property (pa_on |-> ##[0:1] tx_active)
    else $error("amplifier on outside transmit phase");
  a_pll_delay_len: assert property ($rose(tx_active) && seen_q |->
    cnt_q >= 13'hf5e && cnt_q <= 13'hf66)
    else $error("amplifier start delay after clock output wrong");
  a_power_steady: assert property (tx_active && $past(tx_active) |->
    $stable(output_power_level))
    else $error("power level changed during transmit");
  a_off_pins_low: assert property (!en |-> !sck && !serial_in_tx_data)
    else $error("serial pins not low while transmitter off");
  // pin to modulator is two sync flops plus the output flop, so data is three samples old
  a_mod_from_pin: assert property ((amplitude_mod_signal || frequency_mod_signal) |->
    $past(serial_in_tx_data, 3))
    else $error("modulation high without matching pin data");
endmodule

// ---- tb_tx_config_and_start_sequencer.sv ----
// Purpose: self-checking bench, host end against device end over the link
// Assumes: oscillator settle shortened to 1000 cycles, second device to 50
// Notes: second device is fed by the bench to send short and slow words
`timescale 1ns/10ps
module tb_tx_config_and_start_sequencer;
  import tcss_pkg::*;
  logic clk_sys, rst_n, start, stop, tx_bit, busy, sending, cd_b;
  logic [31:0] cfg_word, seed;
  logic crystal_oscillator_on, config_done, tx_active, pa_on;
  logic amplitude_mod_signal, frequency_mod_signal;
  logic [PWR_W-1:0] output_power_level;
  logic [7:0] tops [5] = '{8'hfa, 8'h2e, 8'h9f, 8'hc0, 8'h01};
  int n_errors, checked;
  tcss_link_if link_a ();
  tcss_link_if link_b ();
  tcss_host i_tcss_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_a.host), .start(start),
    .stop(stop), .cfg_word(cfg_word), .tx_bit(tx_bit), .busy(busy), .sending(sending));
  tcss_device #(.OSC_START_CYC(1000)) i_tcss_device (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link_a.device), .crystal_oscillator_on(crystal_oscillator_on),
    .config_done(config_done), .tx_active(tx_active), .pa_on(pa_on),
    .amplitude_mod_signal(amplitude_mod_signal), .frequency_mod_signal(frequency_mod_signal),
    .output_power_level(output_power_level));
  tcss_device #(.OSC_START_CYC(50)) i_tcss_device_b (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link_b.device), .crystal_oscillator_on(), .config_done(cd_b), .tx_active(),
    .pa_on(), .amplitude_mod_signal(), .frequency_mod_signal(), .output_power_level());
  tcss_monitor i_tcss_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .en(link_a.en),
    .sck(link_a.sck), .serial_in_tx_data(link_a.serial_in_tx_data), .clk_out(link_a.clk_out),
    .crystal_oscillator_on(crystal_oscillator_on), .config_done(config_done),
    .tx_active(tx_active), .pa_on(pa_on), .amplitude_mod_signal(amplitude_mod_signal),
    .frequency_mod_signal(frequency_mod_signal), .output_power_level(output_power_level));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // rises over an 80 cycle window: /2 gives 40, /4 gives 20, output off gives none
  function automatic int exp_rises(input logic [7:0] t);
    return t[1] ? (t[2] ? 20 : 40) : 0;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // counts clock output rises over a window, sampled once a system cycle
  task automatic count_rises(input logic b_side, input int len, output int rises);
    logic p;
    rises = 0;
    repeat (len) begin
      p = b_side ? link_b.clk_out : link_a.clk_out;
      tick(1);
      if ((b_side ? link_b.clk_out : link_a.clk_out) && !p) rises++;
    end
  endtask
  // bench plays a slow host on the second link, 40 cycles each half
  task automatic bit_b(input logic b);
    link_b.serial_in_tx_data = b;
    tick(40);
    link_b.sck = 1'b1;
    tick(40);
    link_b.sck = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // one power-up, program, transmit and power-down through the host
  // ----------------------------------------------------------------
  task automatic run_case(input logic [7:0] top);
    int n, rises, exp;
    logic ask, only, b;
    seed = xs(seed);
    cfg_word = {top, seed[23:0]};
    ask = top[7];
    only = top[0];
    start = 1'b1;
    tick(1);
    start = 1'b0;
    n = 1;
    while (sending !== 1'b1 && n < 1500) begin
      tick(1);
      n++;
    end
    tick(8);
    n += 8;
    check({busy, sending, config_done}, 32'h7);
    while (tx_active !== 1'b1 && n < 5200) begin
      tick(1);
      n++;
    end
    // settle then fixed pll delay, measured from the start pulse
    check(32'(n >= 4935 && n <= 4965), 32'(!only));
    count_rises(1'b0, 80, rises);
    exp = exp_rises(top);
    check(32'(rises >= exp - 1 && rises <= exp + 1), 32'h1);
    repeat (6) begin
      seed = xs(seed);
      b = seed[0];
      tx_bit = b;
      tick(12);
      check({pa_on, amplitude_mod_signal, frequency_mod_signal},
        only ? 3'b000 : {ask ? b : 1'b1, ask & b, !ask & b});
    end
    check(output_power_level, only ? 4'h0 : top[6:3]);
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    tx_bit = 1'b0;
    tick(10);
    check({crystal_oscillator_on, config_done, tx_active, pa_on, link_a.clk_out,
      link_a.en, link_a.sck, link_a.serial_in_tx_data, busy}, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // about twice the expected run length
  initial begin
    #2_500_000;
    n_errors++;
    complete_run();
  end
  initial begin
    int rises;
    logic [31:0] w;
    rst_n = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    tx_bit = 1'b0;
    cfg_word = 32'h0000_0000;
    seed = 32'h603bcfb1;
    n_errors = 0;
    checked = 0;
    link_b.en = 1'b0;
    link_b.sck = 1'b0;
    link_b.serial_in_tx_data = 1'b0;
    tick(5);
    rst_n = 1'b1;
    tick(2);
    foreach (tops[i]) run_case(tops[i]);
    repeat (3) begin
      seed = xs(seed);
      run_case(seed[31:24]);
    end
    // short word is refused, the 32nd bit then latches and starts the clock at once
    seed = xs(seed);
    w = {8'h82, seed[23:0]};
    link_b.en = 1'b1;
    for (int i = 31; i > 0; i--) bit_b(w[i]);
    tick(100);
    check(cd_b, 32'h0);
    bit_b(w[0]);
    tick(8);
    check(cd_b, 32'h1);
    count_rises(1'b1, 20, rises);
    check(32'(rises >= 9), 32'h1);
    link_b.en = 1'b0;
    link_b.serial_in_tx_data = 1'b0;
    tick(10);
    check(cd_b, 32'h0);
    complete_run();
  end
endmodule
